// ### hw/tws_consts.vh
// Constants for the transmit word type and flag select block
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH
// APB register byte offsets
`define TWS_OFF_CTRL      12'h000
`define TWS_OFF_STATUS    12'h004
`define TWS_OFF_WORD      12'h008
`define TWS_OFF_COUNT     12'h00c
// Control register field positions
`define TWS_CTRL_FLAG_MODE 0
`define TWS_CTRL_SCRAMBLE  1
`define TWS_CTRL_ENABLE    2
// Control reset value: scramble on, block enabled
`define TWS_CTRL_RESET    3'h6
// Word kinds carried with each word
`define TWS_KIND_IDLE     2'h0
`define TWS_KIND_DATA     2'h1
`define TWS_KIND_CTRL     2'h2
// Clock and word rate
`define TWS_CLK_NS        100
`define TWS_WORD_DIV      4
// Launch latency in tenths of a word period
`define TWS_LAT_TENTHS    14
// Serial bits shifted per word (kind header + 18 payload bits)
`define TWS_SER_BITS      20
// Scramble seed
`define TWS_SCR_SEED      7'h5b
`endif

// ### hw/tws_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module tws_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk_in,
  input  wire             srst_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage array
  reg [AW-1:0]    wp_q;            // Write pointer
  reg [AW-1:0]    rp_q;            // Read pointer
  reg [AW:0]      cnt_q;           // Fill level
  wire            do_wr;
  wire            do_rd;

  assign wr_ready_out = (cnt_q != DEPTH[AW:0]);
  assign rd_valid_out = (cnt_q != {(AW+1){1'b0}});
  assign rd_data_out  = mem[rp_q];
  assign do_wr = wr_valid_in & wr_ready_out;
  assign do_rd = rd_valid_out & rd_ready_in;

  // Storage write, no reset needed on data
  always @(posedge clk_in) begin
    if (do_wr) begin
      mem[wp_q] <= wr_data_in;
    end
  end

  // Pointers and level
  always @(posedge clk_in) begin
    if (srst_in) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (do_rd) begin
        rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      // Simultaneous push and pop keeps the level
      case ({do_wr, do_rd})
        2'b10:   cnt_q <= cnt_q + 1'b1;
        2'b01:   cnt_q <= cnt_q - 1'b1;
        default: cnt_q <= cnt_q;
      endcase
    end
  end
endmodule

// ### hw/tws_top.v
// Transmit word selection: type choice, flag select, scramble, serial out
// How it works
// - Flag mode high: user flag is 17th bit
// - Scramble enable scrambles the flag encoding
// - Data request alone sends bits 0-15 plus flag
// - Control word sends bits 0-13 only
// - Both requests together send a control word
// - No request sends an idle word
// - Flag mode low: alternating internal flag
// - Control words never carry a flag
// - First serial bit about 1.4 words later
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "tws_consts.vh"
module tws_top #(
  parameter WORD_DIV = `TWS_WORD_DIV,
  parameter SER_BITS = `TWS_SER_BITS,
  parameter FDEPTH   = 4
) (
  input  wire        CLK_IN,
  input  wire        SRST_IN,
  input  wire [15:0] WORD_IN,
  input  wire        FLAG_BIT_IN,
  input  wire        DATA_WORD_REQUEST_IN,
  input  wire        CONTROL_WORD_REQUEST_IN,
  input  wire        PSEL_IN,
  input  wire        PENABLE_IN,
  input  wire        PWRITE_IN,
  input  wire [11:0] PADDR_IN,
  input  wire [31:0] PWDATA_IN,
  output reg  [31:0] PRDATA_OUT,
  output reg         PREADY_OUT,
  output reg         PSLVERR_OUT,
  output reg         WORD_STROBE_OUT,
  output reg         SERIAL_OUT_POS_OUT,
  output reg         SERIAL_OUT_NEG_OUT
);
  // Word period in ns and latency in ns derived from it
  localparam WORD_NS = `TWS_CLK_NS * WORD_DIV;
  localparam LAT_NS  = (WORD_NS * `TWS_LAT_TENTHS) / 10;
  // Latency rounded down to whole clocks, at least one
  localparam LAT_CYC = (LAT_NS / `TWS_CLK_NS) < 1 ? 1 : (LAT_NS / `TWS_CLK_NS);
  // Wait load: sample, load and shift entry eat three clocks of the latency
  localparam WAIT_LD = (LAT_CYC > 3) ? (LAT_CYC - 3) : 1;

  // Kind header (2 bits) + 18-bit payload field makes one serial frame
  function [SER_BITS-1:0] build_frame;
    input [1:0]  kind;
    input [15:0] word;
    input        flag;
    begin
      case (kind)
        `TWS_KIND_DATA: build_frame = {kind, 1'b0, flag, word};
        `TWS_KIND_CTRL: build_frame = {kind, 4'h0, word[13:0]};
        default:        build_frame = {kind, 18'h00000};
      endcase
    end
  endfunction

  // Seven-bit LFSR step used for flag scrambling
  function [6:0] lfsr_step;
    input [6:0] s;
    begin
      lfsr_step = {s[5:0], s[6] ^ s[5]};
    end
  endfunction

  // Control register and counters
  reg [2:0]  ctrl_q;       // Flag mode, scramble, enable
  reg [15:0] data_cnt_q;   // Data words sent
  reg [15:0] ctrl_cnt_q;   // Control words sent
  reg [1:0]  last_kind_q;  // Kind of last accepted word
  reg        alt_flag_q;   // Internal alternating flag
  reg [6:0]  scr_q;        // Scrambler state
  reg [7:0]  div_q;        // Word period divider
  reg        word_en_q;    // One-cycle word enable
  reg        ovf_q;        // Sticky: word dropped on full FIFO

  wire flag_mode = ctrl_q[`TWS_CTRL_FLAG_MODE];
  wire scr_en    = ctrl_q[`TWS_CTRL_SCRAMBLE];
  wire blk_en    = ctrl_q[`TWS_CTRL_ENABLE];

  // Word clock enable from divider, one pulse per word period
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      div_q     <= 8'h00;
      word_en_q <= 1'b0;
    end else begin
      word_en_q <= (div_q == 8'h00);
      if (div_q == WORD_DIV[7:0] - 8'h01) begin
        div_q <= 8'h00;
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end

  // Word type selection; control wins over data
  reg [1:0] kind_c;
  always @* begin
    if (CONTROL_WORD_REQUEST_IN) begin
      kind_c = `TWS_KIND_CTRL;
    end else if (DATA_WORD_REQUEST_IN) begin
      kind_c = `TWS_KIND_DATA;
    end else begin
      kind_c = `TWS_KIND_IDLE;
    end
  end

  // Flag choice: user flag or internal alternating one, then scrambled
  reg flag_c;
  always @* begin
    flag_c = flag_mode ? FLAG_BIT_IN : alt_flag_q;
    if (scr_en) begin
      flag_c = flag_c ^ scr_q[6];
    end
  end

  // FIFO write side; words are taken only on the word enable
  wire                wr_valid = word_en_q & blk_en;
  wire                wr_ready;
  wire [SER_BITS-1:0] rd_data;
  wire                rd_valid;
  reg                 rd_ready;

  tws_fifo #(
    .WIDTH (SER_BITS),
    .DEPTH (FDEPTH),
    .AW    (2)
  ) u_fifo (
    .clk_in       (CLK_IN),
    .srst_in      (SRST_IN),
    .wr_data_in   (build_frame(kind_c, WORD_IN, flag_c)),
    .wr_valid_in  (wr_valid),
    .wr_ready_out (wr_ready),
    .rd_data_out  (rd_data),
    .rd_valid_out (rd_valid),
    .rd_ready_in  (rd_ready)
  );

  // Per-word state: flag toggles only on accepted data words
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      alt_flag_q  <= 1'b0;
      scr_q       <= `TWS_SCR_SEED;
      data_cnt_q  <= 16'h0000;
      ctrl_cnt_q  <= 16'h0000;
      last_kind_q <= `TWS_KIND_IDLE;
      WORD_STROBE_OUT <= 1'b0;
    end else begin
      WORD_STROBE_OUT <= wr_valid & wr_ready;
      if (wr_valid & wr_ready) begin
        last_kind_q <= kind_c;
        if (kind_c == `TWS_KIND_DATA) begin
          alt_flag_q <= ~alt_flag_q;
          scr_q      <= lfsr_step(scr_q);
          data_cnt_q <= data_cnt_q + 16'h0001;
        end
        if (kind_c == `TWS_KIND_CTRL) begin
          ctrl_cnt_q <= ctrl_cnt_q + 16'h0001;
        end
      end
    end
  end

  // Serializer: waits WAIT_LD clocks after a frame is loaded, then shifts
  localparam S_IDLE  = 2'h0;
  localparam S_WAIT  = 2'h1;
  localparam S_SHIFT = 2'h2;
  reg [1:0]          st_q;
  reg [SER_BITS-1:0] sh_q;       // Shift register, LSB first
  reg [7:0]          bit_cnt_q;  // Bits or wait cycles left

  always @* begin
    rd_ready = (st_q == S_IDLE);
  end

  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      st_q               <= S_IDLE;
      sh_q               <= {SER_BITS{1'b0}};
      bit_cnt_q          <= 8'h00;
      SERIAL_OUT_POS_OUT <= 1'b0;
      SERIAL_OUT_NEG_OUT <= 1'b1;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (rd_valid) begin
            sh_q      <= rd_data;
            bit_cnt_q <= WAIT_LD[7:0];
            st_q      <= S_WAIT;
          end
        end
        S_WAIT: begin
          // Hold the line until the launch latency has passed
          if (bit_cnt_q <= 8'h01) begin
            bit_cnt_q <= SER_BITS[7:0];
            st_q      <= S_SHIFT;
          end else begin
            bit_cnt_q <= bit_cnt_q - 8'h01;
          end
        end
        S_SHIFT: begin
          SERIAL_OUT_POS_OUT <= sh_q[0];
          SERIAL_OUT_NEG_OUT <= ~sh_q[0];
          sh_q      <= {1'b0, sh_q[SER_BITS-1:1]};
          bit_cnt_q <= bit_cnt_q - 8'h01;
          if (bit_cnt_q == 8'h01) begin
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // APB slave: one wait state per access phase, errors on unmapped addresses
  wire apb_acc = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
  // Writes land only at the edge where the master sees ready high
  wire apb_wr  = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;
  wire ovf_set = wr_valid & ~wr_ready;

  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ctrl_q      <= `TWS_CTRL_RESET;
      ovf_q       <= 1'b0;
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= 32'h00000000;
    end else begin
      PREADY_OUT  <= apb_acc;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= 32'h00000000;
      // Set beats clear for the overflow flag
      if (ovf_set) begin
        ovf_q <= 1'b1;
      end else if (apb_wr && PADDR_IN == `TWS_OFF_STATUS && PWDATA_IN[0]) begin
        ovf_q <= 1'b0;
      end
      // Control write on the completing edge
      if (apb_wr && PADDR_IN == `TWS_OFF_CTRL) begin
        ctrl_q <= PWDATA_IN[2:0];
      end
      if (apb_acc) begin
        case (PADDR_IN)
          `TWS_OFF_CTRL:   PRDATA_OUT <= {29'h0, ctrl_q};
          `TWS_OFF_STATUS: PRDATA_OUT <= {27'h0, alt_flag_q, st_q, ovf_q, rd_valid};
          `TWS_OFF_WORD:   PRDATA_OUT <= {30'h0, last_kind_q};
          `TWS_OFF_COUNT:  PRDATA_OUT <= {ctrl_cnt_q, data_cnt_q};
          default:         PSLVERR_OUT <= 1'b1;
        endcase
      end
    end
  end
endmodule

// ### tb/tws_rx_model.sv
// Far-end receiver model: last 20 line bits, first bit lowest
`timescale 1ns/10ps
module tws_rx_model (
  input  wire logic        clk_in,
  input  wire logic        pos_in,
  output logic      [19:0] frame_out
);
  initial frame_out = 20'h0;
  // Shift in from the top so an LSB-first frame lines up
  always @(posedge clk_in) begin
    frame_out <= {pos_in, frame_out[19:1]};
  end
endmodule

// ### tb/tws_top_properties.sv
// Port-level checker for the word selection block
`timescale 1ns/10ps
module tws_top_properties (
  input wire logic        CLK_IN,
  input wire logic        SRST_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        WORD_STROBE_OUT,
  input wire logic        SERIAL_OUT_POS_OUT,
  input wire logic        SERIAL_OUT_NEG_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  // Access phase waiting for its answer
  wire acc = PSEL_IN && PENABLE_IN && !PREADY_OUT;
  // Only the four aligned register words are mapped
  wire mapped = (PADDR_IN == 12'h000) || (PADDR_IN == 12'h004) ||
                (PADDR_IN == 12'h008) || (PADDR_IN == 12'h00c);
  property p_rdy; acc |=> PREADY_OUT; endproperty
  a_rdy: assert property (p_rdy) else $error("late ready");
  property p_pulse; PREADY_OUT |=> !PREADY_OUT; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_idle; !PSEL_IN |=> !PREADY_OUT; endproperty
  a_idle: assert property (p_idle) else $error("ready unasked");
  property p_err; acc && !mapped |=> PSLVERR_OUT && PRDATA_OUT == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_ok; acc && mapped |=> !PSLVERR_OUT; endproperty
  a_ok: assert property (p_ok) else $error("mapped refused");
  property p_stb; WORD_STROBE_OUT |=> !WORD_STROBE_OUT [*3]; endproperty
  a_stb: assert property (p_stb) else $error("words too close");
  property p_line; SERIAL_OUT_POS_OUT != SERIAL_OUT_NEG_OUT; endproperty
  a_line: assert property (p_line) else $error("line not complementary");
  // Nothing may leave before the launch delay after reset
  property p_lat; $fell(SRST_IN) |-> !SERIAL_OUT_POS_OUT [*5]; endproperty
  a_lat: assert property (p_lat) else $error("early first bit");
  c_err: cover property (PSLVERR_OUT);
  c_stb: cover property (WORD_STROBE_OUT);
  c_ser: cover property (SERIAL_OUT_POS_OUT);
endmodule
bind tws_top tws_top_properties i_tws_top_properties (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .WORD_STROBE_OUT(WORD_STROBE_OUT),
  .SERIAL_OUT_POS_OUT(SERIAL_OUT_POS_OUT), .SERIAL_OUT_NEG_OUT(SERIAL_OUT_NEG_OUT));

// ### tb/tws_top_tb.sv
// Self-checking bench for the word selection block
`timescale 1ns/10ps
`include "tws_consts.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tws_top_tb;
  logic        clk = 0, srst = 1, flag = 0, dreq = 0, creq = 0, f;
  logic        psel = 0, pen = 0, pwr = 0, pready, pslverr, strobe, spos, sneg, er;
  logic [15:0] word = 0, w;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [19:0] rx_frame;
  int          bad_count = 0, num_checks = 0, cyc = 0, seed = 32'h48fec3be;
  tws_top i_tws_top (.CLK_IN(clk), .SRST_IN(srst), .WORD_IN(word), .FLAG_BIT_IN(flag),
    .DATA_WORD_REQUEST_IN(dreq), .CONTROL_WORD_REQUEST_IN(creq), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .WORD_STROBE_OUT(strobe), .SERIAL_OUT_POS_OUT(spos), .SERIAL_OUT_NEG_OUT(sneg));
  tws_rx_model i_tws_rx_model (.clk_in(clk), .pos_in(spos), .frame_out(rx_frame));
  initial forever #50 clk = ~clk;
  // Hang guard, far above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin bad_count++; end_sim(); end
  end
  task end_sim;
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One APB transfer, held until ready is sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pwr <= wr; paddr <= a; pwdata <= d;
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 0; pen <= 0;
  endtask
  // Expected frame: kind on top, control drops bits 15:14 and the flag
  function automatic logic [19:0] frm(input logic c, fe, input logic [15:0] wd);
    return c ? {`TWS_KIND_CTRL, 4'h0, wd[13:0]} : {`TWS_KIND_DATA, 1'b0, fe, wd};
  endfunction
  // Enable for two words, check the kind, then hunt for the first one's frame
  task automatic send(input logic [1:0] m, input logic d, c, fi, fe, input logic [15:0] wd,
                      input logic look);
    int n = 0;
    logic hit = !look;
    dreq <= d; creq <= c; flag <= fi; word <= wd;
    apb(1, `TWS_OFF_CTRL, {29'h0, 1'b1, m});
    while (strobe !== 1'b1 && n++ < 20) @(posedge clk);
    apb(1, `TWS_OFF_CTRL, {30'h0, m});
    apb(0, `TWS_OFF_WORD, 0);
    `CHK(rd[1:0], c ? `TWS_KIND_CTRL : d ? `TWS_KIND_DATA : `TWS_KIND_IDLE)
    dreq <= 0; creq <= 0;
    repeat (200) begin
      @(posedge clk);
      if (rx_frame === frm(c, fe, wd)) hit = 1;
    end
    `CHK(hit, 1'b1)
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 0;
    apb(0, `TWS_OFF_CTRL, 0);
    `CHK(rd[2:0], `TWS_CTRL_RESET)
    apb(1, `TWS_OFF_CTRL, 32'h2);
    repeat (150) @(posedge clk);
    w = $random(seed);
    f = $random(seed);
    send(2'h3, 1, 0, f, ~f, w, 1);
    // Far end mirrors both mode bits; scrambling off only as legacy
    repeat (3) begin
      w = $random(seed);
      f = $random(seed);
      send(2'h1, 1, 0, f, f, w, 1);
      send(2'h1, 0, 1, 1, 1, w, 1);
      send(2'h1, 1, 1, f, f, w, 1);
      send(2'h1, 0, 0, f, f, w, 0);
      apb(0, `TWS_OFF_STATUS, 0);
      send(2'h0, 1, 0, ~rd[4], rd[4], w, 1);
    end
    apb(0, 12'h010, 0);
    `CHK({er, rd}, 33'h100000000)
    end_sim();
  end
endmodule
